// >>> hw/apcap_pkg.sv
// Package for the axial probe position capture block.
// Assumes an APB slave with 32-bit data and aligned word registers.
package apcap_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] APCAP_CTRL_OFS    = 8'h00;
  localparam logic [7:0] APCAP_TRIG_OFS    = 8'h04;
  localparam logic [7:0] APCAP_STAT_OFS    = 8'h08;
  localparam logic [7:0] APCAP_RES0_OFS    = 8'h10;
  localparam logic [7:0] APCAP_RES1_OFS    = 8'h14;
  localparam logic [7:0] APCAP_RES2_OFS    = 8'h18;
  localparam logic [7:0] APCAP_RES3_OFS    = 8'h1c;
  localparam logic [7:0] APCAP_RING_OFS    = 8'h20;
  localparam logic [7:0] APCAP_RCNT_OFS    = 8'h24;

  // ==========================================================
  // Control field positions
  localparam int APCAP_UNITS_LSB = 0;   // 4 bits, units digit
  localparam int APCAP_TENS_LSB  = 4;   // 4 bits, tens digit
  localparam int APCAP_CONT_BIT  = 8;   // continuous command
  localparam int APCAP_EXT_BIT   = 9;   // extended telegram
  localparam int APCAP_RBUF_LSB  = 12;  // 4 bits, ring buffer 1..10
  localparam int APCAP_NTRG_LSB  = 16;  // 3 bits, trigger count
  localparam int APCAP_START_BIT = 31;  // write 1 to start

  localparam logic [31:0] APCAP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] APCAP_TRIG_RST = 32'h0000_0000;

  // ==========================================================
  // Modes and trigger codes (3-bit signed code per trigger)
  localparam logic [3:0] APCAP_M_ABORT = 4'h0;
  localparam logic [3:0] APCAP_M_PAR   = 4'h1;
  localparam logic [3:0] APCAP_M_SEQE  = 4'h2;
  localparam logic [3:0] APCAP_M_SEQ   = 4'h3;
  localparam logic [3:0] APCAP_E_ACT   = 4'h0;
  localparam logic [3:0] APCAP_E_ONE   = 4'h1;
  localparam logic [3:0] APCAP_E_TWO   = 4'h2;
  localparam logic [3:0] APCAP_E_BOTH  = 4'h3;
  localparam logic [2:0] APCAP_T_R1    = 3'h1;
  localparam logic [2:0] APCAP_T_F1    = 3'h7;
  localparam logic [2:0] APCAP_T_R2    = 3'h2;
  localparam logic [2:0] APCAP_T_F2    = 3'h6;

  localparam int APCAP_NUM_RINGS     = 10;
  localparam int APCAP_EXT_MAX       = 8;
  localparam int APCAP_RATIO_DEF_MAX = 8;
  localparam int APCAP_RATIO_EXT_MAX = 4;

endpackage

// >>> hw/apcap_top.sv
// Axial probe position capture unit with APB register access.
// Assumes probe, encoder and cycle inputs synchronous to pclk.
// What this block does
// - Units digit 0 cancels the pending job, arms nothing more.
// - Units digit 1 arms up to four edges together.
// - Units digit 2 arms edges in order; error if first already true.
// - Units digit 3 arms in order with no start error.
// - Tens 0 uses active encoder; tens 1 the first encoder; continuous rings always take encoder one.
// - Tens 2 uses encoder two if present, else encoder one, silently; rings take encoder one.
// - Tens 3 latches both encoders into result slots; at most two edges armed.
// - Continuous command refuses units mode 3.
// - Trigger codes 1,-1,2,-2 are probe one/two rising/falling.
// - Default telegram: one value per edge per control cycle.
// - Extended continuous: eight rise and eight fall per probe/cycle.
// - Continuous values go to chosen ring; probe two to next ring.
// - Ten ring buffers, depth set by a parameter.
// - Continuous job runs until code 0, ring full, reset, block advance or end.
// - Live probe level flag: 1 deflected, 0 not.
// - Extended telegram limitation flag per probe.
// - Done flag cleared at start, set when probe meets its edge.
// - Both encoders: slots hold edge1 enc1/enc2, edge2 enc1/enc2.
// - Default telegram continuous valid up to 8:1 cycle ratio.
// - Extended telegram continuous valid up to 4:1 cycle ratio.
// - Reading a ring entry removes it.
// - Reset or block advance cancels any pending job.
`timescale 1ns/10ps
module apcap_top
  import apcap_pkg::*;
#(
  parameter int POS_W      = 32,
  parameter int RING_DEPTH = 16,
  parameter bit HAS_ENC2   = 1'b1
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [1:0]       probe_in,
  input  wire logic [1:0]       probe_limit_in,
  input  wire logic [POS_W-1:0] enc1_pos,
  input  wire logic [POS_W-1:0] enc2_pos,
  input  wire logic             enc_active_sel,
  input  wire logic             ctrl_cycle,
  input  wire logic [3:0]       ipo_ratio,
  input  wire logic             block_advance,
  input  wire logic             program_end,
  output logic      [1:0]       probe_level,
  output logic      [1:0]       probe_limited,
  output logic      [1:0]       capture_done_flag,
  output logic                  job_active,
  output logic                  job_error
);

  localparam int PW = $clog2(RING_DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (RING_DEPTH < 2 ||
      (RING_DEPTH & (RING_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("RING_DEPTH must be a power of two of at least 2");
  end
  if (POS_W > 32 || POS_W < 1) begin : g_bad_width
    $error("POS_W must be 1..32");
  end

  // ==========================================================
  // APB decode
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire hit_ctrl = (paddr == APCAP_CTRL_OFS);
  wire hit_trig = (paddr == APCAP_TRIG_OFS);
  wire hit_ring = (paddr == APCAP_RING_OFS);
  wire mapped   = hit_ctrl | hit_trig | hit_ring |
                  (paddr == APCAP_STAT_OFS) | (paddr == APCAP_RCNT_OFS) |
                  (paddr == APCAP_RES0_OFS) | (paddr == APCAP_RES1_OFS) |
                  (paddr == APCAP_RES2_OFS) | (paddr == APCAP_RES3_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  logic [31:0] ctrl_reg;
  logic [31:0] trig_reg;
  wire [3:0] units  = ctrl_reg[APCAP_UNITS_LSB +: 4];
  wire [3:0] tens   = ctrl_reg[APCAP_TENS_LSB +: 4];
  wire       cont   = ctrl_reg[APCAP_CONT_BIT];
  wire       ext    = ctrl_reg[APCAP_EXT_BIT];
  wire [3:0] rsel   = ctrl_reg[APCAP_RBUF_LSB +: 4];
  wire [2:0] ntrg_w = ctrl_reg[APCAP_NTRG_LSB +: 3];
  wire start = wr_en & hit_ctrl & pwdata[APCAP_START_BIT];

  // Write during start goes straight to ctrl_reg, so decode new value
  wire [3:0] n_units = pwdata[APCAP_UNITS_LSB +: 4];
  wire [3:0] n_tens  = pwdata[APCAP_TENS_LSB +: 4];
  wire       n_cont  = pwdata[APCAP_CONT_BIT];
  wire [3:0] n_rsel  = pwdata[APCAP_RBUF_LSB +: 4];
  wire start_ok = start & (n_units != APCAP_M_ABORT)
                & (n_units <= APCAP_M_SEQ)
                & ~(n_cont & (n_units == APCAP_M_SEQ))
                & ~(n_cont & ((n_rsel == 4'h0) |
                    (n_rsel > 4'(APCAP_NUM_RINGS))));
  wire abort = (wr_en & hit_ctrl & (n_units == APCAP_M_ABORT))
             | block_advance | program_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= APCAP_CTRL_RST;
      trig_reg <= APCAP_TRIG_RST;
    end else begin
      if (wr_en & hit_ctrl)
        ctrl_reg <= {1'b0, pwdata[30:0]};
      if (wr_en & hit_trig)
        trig_reg <= pwdata;
    end
  end

  // ==========================================================
  // Probe edges and trigger decode
  logic [1:0] probe_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      probe_d_reg <= 2'b00;
    else
      probe_d_reg <= probe_in;
  end
  wire [1:0] rise = probe_in & ~probe_d_reg;
  wire [1:0] fall = ~probe_in & probe_d_reg;
  assign probe_level   = probe_d_reg;
  assign probe_limited = ext ? probe_limit_in : 2'b00;

  // Both encoders limit the list to two edges
  wire [2:0] ntrg = (tens == APCAP_E_BOTH && ntrg_w > 3'd2) ?
                    3'd2 : (ntrg_w > 3'd4 ? 3'd4 : ntrg_w);

  logic [3:0] tfire;
  logic [3:0] tlevel;
  logic [3:0] tprobe2;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_trig
      wire [2:0] code = trig_reg[g*4 +: 3];
      always_comb begin
        tfire[g]   = 1'b0;
        tlevel[g]  = 1'b0;
        tprobe2[g] = 1'b0;
        unique case (code)
          APCAP_T_R1: begin tfire[g] = rise[0]; tlevel[g] = probe_in[0]; end
          APCAP_T_F1: begin tfire[g] = fall[0]; tlevel[g] = ~probe_in[0]; end
          APCAP_T_R2: begin
            tfire[g] = rise[1]; tlevel[g] = probe_in[1]; tprobe2[g] = 1'b1;
          end
          APCAP_T_F2: begin
            tfire[g] = fall[1]; tlevel[g] = ~probe_in[1]; tprobe2[g] = 1'b1;
          end
          default: ;
        endcase
      end
    end
  endgenerate

  // ==========================================================
  // Encoder selection
  wire use2 = (tens == APCAP_E_ACT) ? enc_active_sel :
              (tens == APCAP_E_TWO) ? HAS_ENC2 : 1'b0;
  wire [POS_W-1:0] sel_pos = (use2 && HAS_ENC2) ? enc2_pos : enc1_pos;

  // ==========================================================
  // Job control
  logic       active_reg;
  logic       error_reg;
  logic       cont_reg;
  logic [1:0] seq_reg;
  logic [3:0] used_reg;         // Edges already served this control cycle
  logic [3:0] got_reg;          // Edges already served this job
  logic [3:0] ecnt_r_reg [2];   // Extended: rises per probe per cycle
  logic [3:0] ecnt_f_reg [2];
  logic [1:0] done_reg;
  logic [POS_W-1:0] res_reg [4];

  wire seq_mode = (units == APCAP_M_SEQE) | (units == APCAP_M_SEQ);
  logic [3:0] armed;
  always_comb begin
    armed = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(ntrg))
        armed[i] = seq_mode ? (seq_reg == 2'(i)) : 1'b1;
    end
  end

  // Per-cycle quota: default one capture per edge, extended continuous up to eight
  logic [3:0] hit;
  always_comb begin
    hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (active_reg && armed[i] && tfire[i]) begin
        if (cont_reg && ext)
          hit[i] = (trig_reg[i*4+2] ?
                    ecnt_f_reg[tprobe2[i]] : ecnt_r_reg[tprobe2[i]])
                   < 4'(APCAP_EXT_MAX);
        else
          hit[i] = ~used_reg[i] & (cont_reg | ~got_reg[i]);
      end
    end
  end
  wire any_hit = |hit;
  logic [1:0] hit_idx;
  always_comb begin
    hit_idx = 2'd0;
    for (int i = 3; i >= 0; i--)
      if (hit[i]) hit_idx = 2'(i);
  end
  wire hit_p2 = tprobe2[hit_idx];
  // A hit in the cycle-start clock counts towards the new cycle
  wire [3:0] ef_base = ctrl_cycle ? 4'd0 : ecnt_f_reg[hit_p2];
  wire [3:0] er_base = ctrl_cycle ? 4'd0 : ecnt_r_reg[hit_p2];

  // ==========================================================
  // Ring buffers: one shared array, per-ring pointers
  localparam int RN = APCAP_NUM_RINGS;
  logic [POS_W-1:0] ring_mem [RN][RING_DEPTH];
  logic [PW:0]      wp_reg [RN];
  logic [PW:0]      rp_reg [RN];
  logic [3:0]       rd_sel_reg;
  wire [3:0] ring_base = rsel - 4'd1;
  wire [3:0] ring_w = ring_base + {3'd0, hit_p2};
  wire [PW:0] cnt_w = wp_reg[ring_w] - rp_reg[ring_w];
  wire ring_full = (ring_w < 4'(RN)) && (cnt_w == (PW+1)'(RING_DEPTH));
  wire ring_last = (ring_w < 4'(RN)) &&
                   (cnt_w == (PW+1)'(RING_DEPTH - 1));
  wire ring_wr = active_reg & cont_reg & any_hit & ~ring_full;
  wire [PW:0] cnt_r = wp_reg[rd_sel_reg] - rp_reg[rd_sel_reg];
  wire ring_rd = rd_en & hit_ring & (cnt_r != '0);
  wire ratio_ok = ext ? (ipo_ratio <= 4'(APCAP_RATIO_EXT_MAX))
                      : (ipo_ratio <= 4'(APCAP_RATIO_DEF_MAX));

  always_ff @(posedge pclk) begin
    if (ring_wr)
      ring_mem[ring_w][wp_reg[ring_w][PW-1:0]] <= enc1_pos;
  end

  generate
    for (g = 0; g < RN; g++) begin : g_ring
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wp_reg[g] <= '0;
          rp_reg[g] <= '0;
        end else begin
          if (start_ok && n_cont && (n_rsel == 4'(g + 1) ||
              n_rsel == 4'(g)))
            wp_reg[g] <= rp_reg[g];
          else if (ring_wr && ring_w == 4'(g))
            wp_reg[g] <= wp_reg[g] + 1'b1;
          if (ring_rd && rd_sel_reg == 4'(g))
            rp_reg[g] <= rp_reg[g] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 1'b0;
      error_reg  <= 1'b0;
      cont_reg   <= 1'b0;
      seq_reg    <= 2'd0;
      used_reg   <= 4'h0;
      done_reg   <= 2'b00;
      got_reg    <= 4'h0;
      rd_sel_reg <= 4'd0;
      for (int p = 0; p < 2; p++) begin
        ecnt_r_reg[p] <= 4'd0;
        ecnt_f_reg[p] <= 4'd0;
      end
    end else begin
      if (wr_en && hit_ctrl && n_rsel != 4'd0 &&
          n_rsel <= 4'(APCAP_NUM_RINGS))
        rd_sel_reg <= n_rsel - 4'd1;
      if (abort) begin
        active_reg <= 1'b0;
      end else if (start_ok) begin
        active_reg <= 1'b1;
        cont_reg   <= n_cont;
        seq_reg    <= 2'd0;
        used_reg   <= 4'h0;
        done_reg   <= 2'b00;
        got_reg    <= 4'h0;
        error_reg  <= (n_units == APCAP_M_SEQE) & tlevel[0];
        if (n_units == APCAP_M_SEQE && tlevel[0])
          active_reg <= 1'b0;
      end else if (start) begin
        error_reg <= 1'b1;
      end else if (active_reg) begin
        used_reg <= (ctrl_cycle ? 4'h0 : used_reg) | hit;
        got_reg  <= got_reg | hit;
        if (ctrl_cycle) begin
          for (int p = 0; p < 2; p++) begin
            ecnt_r_reg[p] <= 4'd0;
            ecnt_f_reg[p] <= 4'd0;
          end
        end
        if (any_hit) begin
          if (trig_reg[hit_idx*4+2])
            ecnt_f_reg[hit_p2] <= ef_base + 4'd1;
          else
            ecnt_r_reg[hit_p2] <= er_base + 4'd1;
        end
        if (any_hit) begin
          done_reg[hit_p2] <= 1'b1;
          if (seq_mode)
            seq_reg <= seq_reg + 2'd1;
          if (!cont_reg && ((seq_mode && seq_reg == 2'(ntrg - 3'd1)) ||
              (!seq_mode && (got_reg | hit) == armed)))
            active_reg <= 1'b0;
          if (cont_reg && !ratio_ok)
            error_reg <= 1'b1;
        end
        // Filling the last free slot ends the job as well
        if (cont_reg && any_hit && (ring_full || ring_last))
          active_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Result slots
  wire [1:0] edge_no = seq_mode ? seq_reg : hit_idx;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < 4; s++)
        res_reg[s] <= '0;
    end else if (active_reg && !cont_reg && any_hit) begin
      if (tens == APCAP_E_BOTH) begin
        res_reg[{edge_no[0], 1'b0}] <= enc1_pos;
        res_reg[{edge_no[0], 1'b1}] <= enc2_pos;
      end else begin
        res_reg[edge_no] <= sel_pos;
      end
    end
  end

  assign capture_done_flag = done_reg;
  assign job_active        = active_reg;
  assign job_error         = error_reg;

  // ==========================================================
  // Read mux
  wire [31:0] stat_w = {23'd0, HAS_ENC2, error_reg, active_reg,
                        probe_limited, probe_level, done_reg};
  logic [31:0] rdata_w;
  always_comb begin
    rdata_w = 32'h0000_0000;
    unique case (paddr)
      APCAP_CTRL_OFS: rdata_w = ctrl_reg;
      APCAP_TRIG_OFS: rdata_w = trig_reg;
      APCAP_STAT_OFS: rdata_w = stat_w;
      APCAP_RES0_OFS: rdata_w = 32'(res_reg[0]);
      APCAP_RES1_OFS: rdata_w = 32'(res_reg[1]);
      APCAP_RES2_OFS: rdata_w = 32'(res_reg[2]);
      APCAP_RES3_OFS: rdata_w = 32'(res_reg[3]);
      APCAP_RING_OFS: rdata_w = (cnt_r != '0) ?
        32'(ring_mem[rd_sel_reg][rp_reg[rd_sel_reg][PW-1:0]]) : 32'h0;
      APCAP_RCNT_OFS: rdata_w = 32'(cnt_r);
      default: rdata_w = 32'h0000_0000;
    endcase
  end
  assign prdata = rdata_w;

endmodule

// >>> testbench/apcap_probe_model.sv
// Touch probes and axis encoders facing the capture block.
// Assumes one bench process calls move() at a time.
`timescale 1ns/10ps
module apcap_probe_model #(
  parameter int POS_W = 32
)(
  input  wire logic             pclk,
  output logic      [1:0]       probe_in,
  output logic      [1:0]       probe_limit_in,
  output logic      [POS_W-1:0] enc1_pos,
  output logic      [POS_W-1:0] enc2_pos,
  output logic                  ctrl_cycle
);
  logic             hold;
  logic [1:0]       cyc;
  logic [POS_W-1:0] frz1;
  logic [POS_W-1:0] frz2;
  initial begin
    {probe_in, probe_limit_in, cyc, ctrl_cycle, hold} = 8'h0;
    enc1_pos = '0;
    enc2_pos = '0;
  end
  // ======
  // Axis moves each cycle; frozen around a probe edge so the latch is known
  always @(posedge pclk) begin
    cyc            <= cyc + 2'h1;
    ctrl_cycle     <= (cyc == 2'h3);
    probe_limit_in <= 2'($urandom);
    enc1_pos       <= hold ? frz1 : enc1_pos + POS_W'(1);
    enc2_pos       <= hold ? frz2 : enc2_pos - POS_W'(3);
  end
  // Bounce-free level change, spaced beyond one control cycle
  task automatic move(input int p, input logic l,
                      input logic [POS_W-1:0] a, b);
    @(posedge pclk);
    frz1 <= a;
    frz2 <= b;
    hold <= 1'b1;
    repeat (2) @(posedge pclk);
    probe_in[p] <= l;
    repeat (5) @(posedge pclk);
    hold <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// >>> testbench/apcap_top_checker.sv
// Port-level assertions for the capture block.
// Assumes the single pclk domain with presetn as asynchronous reset.
`timescale 1ns/10ps
module apcap_top_checker
  import apcap_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0]  probe_in,
  input wire logic [1:0]  probe_limit_in,
  input wire logic        block_advance,
  input wire logic        program_end,
  input wire logic [1:0]  probe_level,
  input wire logic [1:0]  probe_limited,
  input wire logic [1:0]  capture_done_flag,
  input wire logic        job_active
);
  logic ctrl_abort;
  assign ctrl_abort = psel && penable && pwrite &&
                      paddr == APCAP_CTRL_OFS &&
                      pwdata[3:0] == APCAP_M_ABORT;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // Probe flags
  a_level_live: assert property (
    1'b1 |=> probe_level == $past(probe_in))
    else $error("probe level does not follow probe input");
  a_limit_gated: assert property (
    (probe_limited & ~probe_limit_in) == 2'h0)
    else $error("limitation flag without its input");
  // ======
  // Done flags need a recent probe edge and clear at job start
  a_done_one: assert property (
    $rose(capture_done_flag[0]) |->
      $past(probe_in[0], 1) != $past(probe_in[0], 2) ||
      $past(probe_in[0], 2) != $past(probe_in[0], 3) ||
      $past(probe_in[0], 3) != $past(probe_in[0], 4))
    else $error("probe one done without an edge");
  a_done_two: assert property (
    $rose(capture_done_flag[1]) |->
      $past(probe_in[1], 1) != $past(probe_in[1], 2) ||
      $past(probe_in[1], 2) != $past(probe_in[1], 3) ||
      $past(probe_in[1], 3) != $past(probe_in[1], 4))
    else $error("probe two done without an edge");
  a_start_clear: assert property (
    $rose(job_active) |-> capture_done_flag == 2'h0)
    else $error("done flags not cleared at job start");
  // ======
  // Job cancellation
  a_abort_write: assert property (
    ctrl_abort |-> ##[1:2] !job_active)
    else $error("abort write left the job running");
  a_block_cancel: assert property (
    block_advance |-> ##[1:2] !job_active)
    else $error("block advance left the job running");
  a_end_cancel: assert property (
    program_end |-> ##[1:2] !job_active)
    else $error("program end left the job running");
endmodule

bind apcap_top apcap_top_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .probe_in(probe_in),
  .probe_limit_in(probe_limit_in), .block_advance(block_advance),
  .program_end(program_end), .probe_level(probe_level),
  .probe_limited(probe_limited), .capture_done_flag(capture_done_flag),
  .job_active(job_active));

// >>> testbench/test_apcap_top.sv
// Self-checking bench for the capture block over APB.
// Assumes zero-wait APB slave and the probe model as far side.
`timescale 1ns/10ps
module test_apcap_top
  import apcap_pkg::*;
;
  localparam int          PW   = 32;
  localparam logic [31:0] T_R1 = {29'h0, APCAP_T_R1};
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          ctrl_cycle, block_advance, program_end, job_active;
  logic          job_error, enc_sel;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata;
  logic [1:0]    probe_in, probe_limit_in, probe_level, probe_limited;
  logic [1:0]    capture_done_flag;
  logic [PW-1:0] enc1_pos, enc2_pos;
  logic [64:0]   exp_q[$];
  logic [64:0]   ent;
  logic [PW-1:0] h1[$], h2[$];
  int            error_cnt = 0, n_checks = 0, cyc = 0;

  apcap_top #(.POS_W(PW), .RING_DEPTH(4), .HAS_ENC2(1'b1)) i_apcap_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .probe_in(probe_in),
    .probe_limit_in(probe_limit_in), .enc1_pos(enc1_pos),
    .enc2_pos(enc2_pos), .enc_active_sel(enc_sel), .ctrl_cycle(ctrl_cycle),
    .ipo_ratio(4'h1), .block_advance(block_advance),
    .program_end(program_end), .probe_level(probe_level),
    .probe_limited(probe_limited), .capture_done_flag(capture_done_flag),
    .job_active(job_active), .job_error(job_error));
  apcap_probe_model #(.POS_W(PW)) i_apcap_probe_model (
    .pclk(pclk), .probe_in(probe_in), .probe_limit_in(probe_limit_in),
    .enc1_pos(enc1_pos), .enc2_pos(enc2_pos), .ctrl_cycle(ctrl_cycle));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // ======
  // Bus tasks and result watcher
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic er);
    exp_q.push_back({er, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  // Read data taken at the access edge, before a popping read moves on
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      chk($sformatf("read %h", paddr), {ent[64], ent[31:0]},
          {pslverr, prdata & ent[63:32]});
    end
  end
  task automatic go(input logic [31:0] tw, input logic [3:0] u, t,
                    input logic c, input logic [3:0] r, input logic [2:0] n);
    h1.delete();
    h2.delete();
    apb(1'b1, APCAP_TRIG_OFS, tw);
    apb(1'b1, APCAP_CTRL_OFS, (32'(n) << APCAP_NTRG_LSB) |
        (32'(r) << APCAP_RBUF_LSB) | (32'(c) << APCAP_CONT_BIT) |
        (32'(t) << APCAP_TENS_LSB) | 32'(u) | 32'h8000_0000);
  endtask
  task automatic mv(input int p, input logic l);
    logic [PW-1:0] a, b;
    a = PW'($urandom);
    b = PW'($urandom);
    h1.push_back(a);
    h2.push_back(b);
    i_apcap_probe_model.move(p, l, a, b);
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic kill(input logic blk);
    go(T_R1, APCAP_M_PAR, APCAP_E_ONE, 1'b0, 4'h1, 3'h1);
    block_advance <= blk;
    program_end   <= !blk;
    @(posedge pclk);
    block_advance <= 1'b0;
    program_end   <= 1'b0;
    rd(APCAP_STAT_OFS, 32'h0, 32'h40, 1'b0);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ======
  // Scenarios
  initial begin
    {psel, penable, pwrite, block_advance, program_end, presetn} = 6'h0;
    enc_sel = 1'b0;
    paddr  = 8'h0;
    pwdata = 32'h0;
    void'($urandom(89));
    rst();
    rd(APCAP_CTRL_OFS, 32'h0, '1, 1'b0);
    rd(APCAP_STAT_OFS, 32'h100, '1, 1'b0);
    rd(8'h3c, 32'h0, '1, 1'b1);
    $display("test reset done");
    go({25'h0, APCAP_T_F2, 1'b0, APCAP_T_R1}, APCAP_M_PAR, APCAP_E_ONE,
       1'b0, 4'h1, 3'h2);
    rd(APCAP_STAT_OFS, 32'h140, 32'h1cf, 1'b0);
    mv(0, 1'b1);
    mv(1, 1'b1);
    mv(1, 1'b0);
    rd(APCAP_RES0_OFS, h1[0], '1, 1'b0);
    rd(APCAP_RES1_OFS, h1[2], '1, 1'b0);
    rd(APCAP_STAT_OFS, 32'h107, 32'h1cf, 1'b0);
    $display("test parallel done");
    go({25'h0, APCAP_T_F1, 1'b0, APCAP_T_R1}, APCAP_M_PAR, APCAP_E_BOTH,
       1'b0, 4'h1, 3'h2);
    mv(0, 1'b0);
    mv(0, 1'b1);
    rd(APCAP_RES0_OFS, h1[1], '1, 1'b0);
    rd(APCAP_RES1_OFS, h2[1], '1, 1'b0);
    rd(APCAP_RES2_OFS, h1[0], '1, 1'b0);
    rd(APCAP_RES3_OFS, h2[0], '1, 1'b0);
    $display("test both encoders done");
    enc_sel <= 1'b1;
    go({25'h0, APCAP_T_R2, 1'b0, APCAP_T_R1}, APCAP_M_SEQ, APCAP_E_ACT,
       1'b0, 4'h1, 3'h2);
    rd(APCAP_STAT_OFS, 32'h40, 32'hc0, 1'b0);
    mv(1, 1'b1);
    mv(1, 1'b0);
    mv(0, 1'b0);
    mv(0, 1'b1);
    mv(1, 1'b1);
    rd(APCAP_RES0_OFS, h2[3], '1, 1'b0);
    rd(APCAP_RES1_OFS, h2[4], '1, 1'b0);
    $display("test sequential done");
    enc_sel <= 1'b0;
    go(T_R1, APCAP_M_PAR, APCAP_E_ONE, 1'b0, 4'h1, 3'h1);
    apb(1'b1, APCAP_CTRL_OFS, 32'h0);
    mv(0, 1'b0);
    mv(0, 1'b1);
    rd(APCAP_STAT_OFS, 32'h0, 32'h41, 1'b0);
    go(T_R1, APCAP_M_SEQ, APCAP_E_ONE, 1'b1, 4'h3, 3'h1);
    rd(APCAP_STAT_OFS, 32'h80, 32'hc0, 1'b0);
    $display("test abort and refusal done");
    rst();
    go(T_R1, APCAP_M_PAR, APCAP_E_ONE, 1'b1, 4'h3, 3'h1);
    for (int i = 0; i < 4; i++) begin
      mv(0, 1'b0);
      mv(0, 1'b1);
    end
    rd(APCAP_RCNT_OFS, 32'h4, '1, 1'b0);
    rd(APCAP_STAT_OFS, 32'h0, 32'hc0, 1'b0);
    for (int i = 0; i < 4; i++)
      rd(APCAP_RING_OFS, h1[2*i+1], '1, 1'b0);
    rd(APCAP_RCNT_OFS, 32'h0, '1, 1'b0);
    $display("test continuous done");
    go(T_R1, APCAP_M_SEQE, APCAP_E_ONE, 1'b0, 4'h1, 3'h1);
    rd(APCAP_STAT_OFS, 32'h80, 32'hc0, 1'b0);
    kill(1'b1);
    kill(1'b0);
    $display("test cancel done");
    complete_run();
  end
endmodule
